// File: verilog/dif_defines.svh
// Constants for the digital input function dispatch: offsets, fields, resets, timing.
// What this block does
// - Function code 0 means unused and is every input's power-up function.
// - Code 1 requests clearing all faults once per activation edge.
// - Fault clear keeps a fault latched while its cause is still present.
// - Code 2 starts task numbered by aux value; position mode, service source.
// - After a start, ignore start inputs until done and while motion active.
// - Code 3 inputs select task 1..127, or 0 for homing; position/service.
// - Code 4 rising starts selected task or homing, falling cancels it.
// - Code 5 rising starts homing, falling does nothing; position/service.
// - Code 6 jogs at aux velocity on rise, stops on fall; velocity/position, service source.
// - Code 8 captures position as zero offset, then requests nonvolatile save.
// - Code 9 aux value 1..4 picks one of four 128-character buffer pairs.
// - Command buffer: rising runs high buffer, falling runs low buffer.
// - Code 10 level 1 raises external fault 245, level 0 is normal.
// - Code 11 passes input as home reference switch; position/service.
// - Code 13 requests ramped controlled stop then power stage off.
// - Code 15 issues quick stop; service or gearing source only.
// - Code 16 rising activates gearing; position mode, gearing source.
// - Code 17 rising adds aux position shift to gearing; position/gearing.
// - A fixed enable input exists apart from the programmable inputs.
// - Programmable inputs are debounced so one physical toggle gives one trigger.
`ifndef DIF_DEFINES_SVH
`define DIF_DEFINES_SVH
`define DIF_OFS_CTRL 8'h00
`define DIF_OFS_STATUS 8'h04
`define DIF_OFS_ZOFS 8'h08
`define DIF_OFS_CH_BASE 8'h10
`define DIF_CH_STRIDE_LOG2 3
`define DIF_CTRL_OPMODE_LSB 0
`define DIF_CTRL_SRC_LSB 2
`define DIF_CTRL_RST 4'h0
`define DIF_FSEL_RST 5'h00
`define DIF_AUX_RST 32'h00000000
`define DIF_STAT_SEL_LSB 0
`define DIF_STAT_LOCK_BIT 7
`define DIF_STAT_LVL_LSB 8
`define DIF_STAT_FLT_LSB 16
`define DIF_EXT_FAULT_NUM 8'hf5
`define DIF_TASK_W 7
`define DIF_CMDBUF_LEN 128
`define DIF_CMDBUF_PAIRS 4
`define DIF_CLK_PERIOD_NS 4
`define DIF_DEBOUNCE_NS 1000
`define DIF_DEBOUNCE_CYC ((`DIF_DEBOUNCE_NS + `DIF_CLK_PERIOD_NS - 1) / `DIF_CLK_PERIOD_NS)
`endif

// File: verilog/dif_pkg.sv
// Types shared by the digital input function dispatch modules.
package dif_pkg;
	typedef enum logic [4:0] {
		DIF_F_OFF = 5'h00,
		DIF_F_FAULT_RESET = 5'h01,
		DIF_F_START_TASK = 5'h02,
		DIF_F_TASK_SELECT = 5'h03,
		DIF_F_START_SELECTED = 5'h04,
		DIF_F_START_HOME = 5'h05,
		DIF_F_JOG = 5'h06,
		DIF_F_ZERO_LATCH = 5'h08,
		DIF_F_CMD_BUFFER = 5'h09,
		DIF_F_EXT_FAULT = 5'h0a,
		DIF_F_HOME_REF = 5'h0b,
		DIF_F_CTRL_STOP = 5'h0d,
		DIF_F_QUICK_STOP = 5'h0f,
		DIF_F_GEAR_ON = 5'h10,
		DIF_F_GEAR_SHIFT = 5'h11
	} dif_func_t;
	typedef enum logic [1:0] {
		DIF_OP_TORQUE = 2'h0,
		DIF_OP_VELOCITY = 2'h1,
		DIF_OP_POSITION = 2'h2
	} dif_opmode_t;
	typedef enum logic [1:0] {
		DIF_SRC_SERVICE = 2'h0,
		DIF_SRC_FIELDBUS = 2'h1,
		DIF_SRC_GEARING = 2'h2,
		DIF_SRC_ANALOG = 2'h3
	} dif_src_t;
	typedef enum logic {
		DIF_ZL_IDLE = 1'b0,
		DIF_ZL_SAVE = 1'b1
	} dif_zl_state_t;
endpackage

// File: verilog/dif_evt_if.sv
// Conditioned input levels and one-cycle edge events between the dispatch modules.
`timescale 1ns/1ps
`default_nettype none
interface dif_evt_if #(parameter int N_IN = 7);
	logic [N_IN-1:0] level;
	logic [N_IN-1:0] rise;
	logic [N_IN-1:0] fall;
	modport src(output level, output rise, output fall);
	modport dst(input level, input rise, input fall);
endinterface
`default_nettype wire

// File: verilog/dif_in_cond.sv
// Synchroniser, debouncer and edge detector for the programmable inputs.
`timescale 1ns/1ps
`default_nettype none
`include "dif_defines.svh"
module dif_in_cond #(
	parameter int N_IN = 7,
	parameter int DEB_CYC = `DIF_DEBOUNCE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [N_IN-1:0] din_raw,
	dif_evt_if.src evt
);
	import dif_pkg::*;
	localparam int CW = $clog2(DEB_CYC + 1);

	genvar i;
	generate
		for (i = 0; i < N_IN; i++) begin : g_ch
			logic sync1_ff;
			logic sync2_ff;
			logic stable_ff;
			logic prev_ff;
			logic [CW-1:0] cnt_ff;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					sync1_ff <= 1'b0;
					sync2_ff <= 1'b0;
				end else begin
					sync1_ff <= din_raw[i];
					sync2_ff <= sync1_ff;
				end
			end
			// debounce stable window
			// A change must hold for the whole window, so bounce restarts the count.
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cnt_ff <= '0;
					stable_ff <= 1'b0;
				end else if (sync2_ff == stable_ff) begin
					cnt_ff <= '0;
				end else if (cnt_ff == CW'(DEB_CYC - 1)) begin
					cnt_ff <= '0;
					stable_ff <= sync2_ff;
				end else begin
					cnt_ff <= cnt_ff + 1'b1;
				end
			end
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					prev_ff <= 1'b0;
				end else begin
					prev_ff <= stable_ff;
				end
			end
			assign evt.level[i] = stable_ff;
			assign evt.rise[i] = stable_ff & ~prev_ff;
			assign evt.fall[i] = ~stable_ff & prev_ff;

			AST_RISE_ONE_CYCLE: assert property (@(posedge hclk) disable iff (!hresetn)
				(stable_ff & ~prev_ff) |=> !(stable_ff & ~prev_ff))
				else $error("Rising event lasted more than one cycle.");
		end
	endgenerate
endmodule
`default_nettype wire

// File: verilog/dif_top.sv
// Digital input function dispatch with its AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "dif_defines.svh"
module dif_top #(
	parameter int N_IN = 7,
	parameter int FW = 16,
	parameter int DEB_CYC = `DIF_DEBOUNCE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [N_IN-1:0] din_raw,
	input wire logic enable_in,
	input wire logic motion_busy,
	input wire logic task_done,
	input wire logic [FW-1:0] fault_cond,
	input wire logic [31:0] cur_position,
	output logic drive_enable,
	output logic fault_clear_req,
	output logic [FW-1:0] fault_latched,
	output logic ext_fault,
	output logic [7:0] ext_fault_num,
	output logic task_start,
	output logic task_cancel,
	output logic [`DIF_TASK_W-1:0] task_num,
	output logic home_start,
	output logic jog_start,
	output logic jog_stop,
	output logic [31:0] jog_velocity,
	output logic [31:0] zero_offset,
	output logic nv_save_req,
	output logic cmdbuf_exec,
	output logic cmdbuf_high,
	output logic [1:0] cmdbuf_pair,
	output logic home_ref_sw,
	output logic ctrl_stop,
	output logic quick_stop,
	output logic gear_activate,
	output logic gear_shift,
	output logic [31:0] gear_shift_dist,
	output dif_pkg::dif_opmode_t opmode_out
);
	import dif_pkg::*;

	dif_evt_if #(.N_IN(N_IN)) evt ();

	dif_in_cond #(.N_IN(N_IN), .DEB_CYC(DEB_CYC)) u_cond (
		.hclk(hclk),
		.hresetn(hresetn),
		.din_raw(din_raw),
		.evt(evt)
	);

	dif_opmode_t opmode_ff;
	dif_src_t src_ff;
	dif_func_t fsel_ff [N_IN];
	logic [31:0] aux_ff [N_IN];
	logic lock_ff;
	logic [FW-1:0] fault_latch_ff;
	logic en_s1_ff;
	logic en_s2_ff;
	dif_zl_state_t zl_state_ff;
	logic [31:0] zofs_ff;
	logic nv_save_ff;
	logic wr_pend_ff;
	logic rd_pend_ff;
	logic [7:0] dph_addr_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] rd_val;

	// Registered action outputs and their next values.
	logic fclr_ff, nxt_fclr;
	logic ext_ff, nxt_ext;
	logic tstart_ff, nxt_tstart;
	logic tcancel_ff, nxt_tcancel;
	logic [`DIF_TASK_W-1:0] tnum_ff, nxt_tnum;
	logic hstart_ff, nxt_hstart;
	logic jstart_ff, nxt_jstart;
	logic jstop_ff, nxt_jstop;
	logic [31:0] jvel_ff, nxt_jvel;
	logic cb_ff, nxt_cb;
	logic cbh_ff, nxt_cbh;
	logic [1:0] cbp_ff, nxt_cbp;
	logic href_ff, nxt_href;
	logic cstop_ff, nxt_cstop;
	logic qstop_ff, nxt_qstop;
	logic gon_ff, nxt_gon;
	logic gsh_ff, nxt_gsh;
	logic [31:0] gdist_ff, nxt_gdist;
	logic zl_trig;
	logic [`DIF_TASK_W-1:0] sel_num;
	logic pos_svc, pos_gear, jog_ok, qs_ok, locked, any_func;
	logic [FW-1:0] cond_all;

	assign pos_svc = (opmode_ff == DIF_OP_POSITION) && (src_ff == DIF_SRC_SERVICE);
	assign pos_gear = (opmode_ff == DIF_OP_POSITION) && (src_ff == DIF_SRC_GEARING);
	assign jog_ok = (src_ff == DIF_SRC_SERVICE) &&
		(opmode_ff == DIF_OP_POSITION || opmode_ff == DIF_OP_VELOCITY);
	assign qs_ok = (src_ff == DIF_SRC_SERVICE) || (src_ff == DIF_SRC_GEARING);
	assign locked = lock_ff | motion_busy;

	// AHB-Lite slave: writes take no wait state, reads take one so data come from a flop.
	logic acc;
	assign acc = hsel & hready & htrans[1];
	assign hreadyout = ~rd_pend_ff;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			dph_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= acc & hwrite;
			rd_pend_ff <= acc & ~hwrite;
			if (acc) begin
				dph_addr_ff <= haddr[7:0];
			end
		end
	end

	always_comb begin
		rd_val = 32'h00000000;
		if (dph_addr_ff == `DIF_OFS_CTRL) begin
			rd_val[`DIF_CTRL_OPMODE_LSB +: 2] = opmode_ff;
			rd_val[`DIF_CTRL_SRC_LSB +: 2] = src_ff;
		end else if (dph_addr_ff == `DIF_OFS_STATUS) begin
			rd_val[`DIF_STAT_SEL_LSB +: `DIF_TASK_W] = sel_num;
			rd_val[`DIF_STAT_LOCK_BIT] = locked;
			rd_val[`DIF_STAT_LVL_LSB +: 8] = 8'(evt.level);
			rd_val[`DIF_STAT_FLT_LSB +: 16] = 16'(fault_latch_ff);
		end else if (dph_addr_ff == `DIF_OFS_ZOFS) begin
			rd_val = zofs_ff;
		end
		for (int i = 0; i < N_IN; i++) begin
			if (dph_addr_ff == 8'(`DIF_OFS_CH_BASE + (i << `DIF_CH_STRIDE_LOG2))) begin
				rd_val = {27'h0000000, fsel_ff[i]};
			end else if (dph_addr_ff ==
				8'(`DIF_OFS_CH_BASE + (i << `DIF_CH_STRIDE_LOG2) + 4)) begin
				rd_val = aux_ff[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h00000000;
		end else if (rd_pend_ff) begin
			hrdata_ff <= rd_val;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opmode_ff <= dif_opmode_t'(2'(`DIF_CTRL_RST >> `DIF_CTRL_OPMODE_LSB));
			src_ff <= dif_src_t'(2'(`DIF_CTRL_RST >> `DIF_CTRL_SRC_LSB));
		end else if (wr_pend_ff && dph_addr_ff == `DIF_OFS_CTRL) begin
			opmode_ff <= dif_opmode_t'(hwdata[`DIF_CTRL_OPMODE_LSB +: 2]);
			src_ff <= dif_src_t'(hwdata[`DIF_CTRL_SRC_LSB +: 2]);
		end
	end

	genvar c;
	generate
		for (c = 0; c < N_IN; c++) begin : g_chreg
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					fsel_ff[c] <= dif_func_t'(`DIF_FSEL_RST);
					aux_ff[c] <= `DIF_AUX_RST;
				end else if (wr_pend_ff) begin
					if (dph_addr_ff == 8'(`DIF_OFS_CH_BASE + (c << `DIF_CH_STRIDE_LOG2))) begin
						fsel_ff[c] <= dif_func_t'(hwdata[4:0]);
					end
					if (dph_addr_ff ==
						8'(`DIF_OFS_CH_BASE + (c << `DIF_CH_STRIDE_LOG2) + 4)) begin
						aux_ff[c] <= hwdata;
					end
				end
			end
		end
	endgenerate

	// Dispatch: edges are acted on in the cycle they occur or dropped for good.
	always_comb begin
		int w;
		logic taken;
		w = 0;
		taken = 1'b0;
		sel_num = '0;
		any_func = 1'b0;
		nxt_fclr = 1'b0;
		nxt_ext = 1'b0;
		nxt_tstart = 1'b0;
		nxt_tcancel = 1'b0;
		nxt_tnum = tnum_ff;
		nxt_hstart = 1'b0;
		nxt_jstart = 1'b0;
		nxt_jstop = 1'b0;
		nxt_jvel = jvel_ff;
		nxt_cb = 1'b0;
		nxt_cbh = cbh_ff;
		nxt_cbp = cbp_ff;
		nxt_href = 1'b0;
		nxt_cstop = 1'b0;
		nxt_qstop = 1'b0;
		nxt_gon = 1'b0;
		nxt_gsh = 1'b0;
		nxt_gdist = gdist_ff;
		zl_trig = 1'b0;
		for (int i = 0; i < N_IN; i++) begin
			if (fsel_ff[i] == DIF_F_TASK_SELECT && w < `DIF_TASK_W) begin
				if (evt.level[i] && pos_svc) begin
					sel_num = sel_num | (`DIF_TASK_W'(1) << w);
				end
				w = w + 1;
			end
		end
		for (int i = 0; i < N_IN; i++) begin
			if (fsel_ff[i] != DIF_F_OFF) begin
				any_func = 1'b1;
			end
			case (fsel_ff[i])
				DIF_F_FAULT_RESET: begin
					if (evt.rise[i]) begin
						nxt_fclr = 1'b1;
					end
				end
				DIF_F_START_TASK: begin
					if (evt.rise[i] && pos_svc && !locked && !taken) begin
						taken = 1'b1;
						nxt_tstart = 1'b1;
						nxt_tnum = aux_ff[i][`DIF_TASK_W-1:0];
					end
				end
				DIF_F_START_SELECTED: begin
					if (evt.rise[i] && pos_svc && !locked && !taken) begin
						taken = 1'b1;
						nxt_tnum = sel_num;
						if (sel_num == '0) begin
							nxt_hstart = 1'b1;
						end else begin
							nxt_tstart = 1'b1;
						end
					end else if (evt.fall[i] && pos_svc) begin
						nxt_tcancel = 1'b1;
						nxt_tnum = sel_num;
					end
				end
				DIF_F_START_HOME: begin
					if (evt.rise[i] && pos_svc && !locked && !taken) begin
						taken = 1'b1;
						nxt_hstart = 1'b1;
					end
				end
				DIF_F_JOG: begin
					if (evt.rise[i] && jog_ok) begin
						nxt_jstart = 1'b1;
						nxt_jvel = aux_ff[i];
					end else if (evt.fall[i] && jog_ok) begin
						nxt_jstop = 1'b1;
					end
				end
				DIF_F_ZERO_LATCH: begin
					if (evt.rise[i]) begin
						zl_trig = 1'b1;
					end
				end
				DIF_F_CMD_BUFFER: begin
					if (aux_ff[i] >= 32'd1 && aux_ff[i] <= 32'(`DIF_CMDBUF_PAIRS)) begin
						// high on rise, low on fall
						if (evt.rise[i] || evt.fall[i]) begin
							nxt_cb = 1'b1;
							nxt_cbh = evt.rise[i];
							nxt_cbp = 2'(aux_ff[i] - 32'd1);
						end
					end
				end
				DIF_F_EXT_FAULT: begin
					if (evt.level[i]) begin
						nxt_ext = 1'b1;
					end
				end
				DIF_F_HOME_REF: begin
					if (evt.level[i] && pos_svc) begin
						nxt_href = 1'b1;
					end
				end
				DIF_F_CTRL_STOP: begin
					if (evt.level[i]) begin
						nxt_cstop = 1'b1;
					end
				end
				DIF_F_QUICK_STOP: begin
					if (evt.rise[i] && qs_ok) begin
						nxt_qstop = 1'b1;
					end
				end
				DIF_F_GEAR_ON: begin
					if (evt.rise[i] && pos_gear) begin
						nxt_gon = 1'b1;
					end
				end
				DIF_F_GEAR_SHIFT: begin
					if (evt.rise[i] && pos_gear) begin
						nxt_gsh = 1'b1;
						nxt_gdist = aux_ff[i];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{fclr_ff, ext_ff, tstart_ff, tcancel_ff, hstart_ff} <= 5'h00;
			{jstart_ff, jstop_ff, cb_ff, cbh_ff, href_ff, cstop_ff} <= 6'h00;
			{qstop_ff, gon_ff, gsh_ff} <= 3'h0;
			tnum_ff <= '0;
			jvel_ff <= 32'h00000000;
			cbp_ff <= 2'h0;
			gdist_ff <= 32'h00000000;
		end else begin
			{fclr_ff, ext_ff, tstart_ff, tcancel_ff, hstart_ff} <=
				{nxt_fclr, nxt_ext, nxt_tstart, nxt_tcancel, nxt_hstart};
			{jstart_ff, jstop_ff, cb_ff, cbh_ff, href_ff, cstop_ff} <=
				{nxt_jstart, nxt_jstop, nxt_cb, nxt_cbh, nxt_href, nxt_cstop};
			{qstop_ff, gon_ff, gsh_ff} <= {nxt_qstop, nxt_gon, nxt_gsh};
			tnum_ff <= nxt_tnum;
			jvel_ff <= nxt_jvel;
			cbp_ff <= nxt_cbp;
			gdist_ff <= nxt_gdist;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_ff <= 1'b0;
		end else if (nxt_tstart || nxt_hstart) begin
			lock_ff <= 1'b1;
		end else if (task_done) begin
			lock_ff <= 1'b0;
		end
	end

	// clear keeps live faults
	// Bit 0 carries the external fault; a cause present now re-sets over any clear.
	assign cond_all = fault_cond | {{(FW-1){1'b0}}, ext_ff};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_latch_ff <= '0;
		end else if (fclr_ff) begin
			fault_latch_ff <= cond_all;
		end else begin
			fault_latch_ff <= fault_latch_ff | cond_all;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zl_state_ff <= DIF_ZL_IDLE;
			zofs_ff <= 32'h00000000;
		end else begin
			case (zl_state_ff)
				DIF_ZL_IDLE: begin
					if (zl_trig) begin
						zofs_ff <= cur_position;
						zl_state_ff <= DIF_ZL_SAVE;
					end
				end
				DIF_ZL_SAVE: begin
					zl_state_ff <= DIF_ZL_IDLE;
				end
				default: begin
					zl_state_ff <= DIF_ZL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nv_save_ff <= 1'b0;
		end else begin
			nv_save_ff <= (zl_state_ff == DIF_ZL_SAVE);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_s1_ff <= 1'b0;
			en_s2_ff <= 1'b0;
		end else begin
			en_s1_ff <= enable_in;
			en_s2_ff <= en_s1_ff;
		end
	end

	assign drive_enable = en_s2_ff;
	assign fault_clear_req = fclr_ff;
	assign fault_latched = fault_latch_ff;
	assign ext_fault = ext_ff;
	assign ext_fault_num = `DIF_EXT_FAULT_NUM;
	assign task_start = tstart_ff;
	assign task_cancel = tcancel_ff;
	assign task_num = tnum_ff;
	assign home_start = hstart_ff;
	assign jog_start = jstart_ff;
	assign jog_stop = jstop_ff;
	assign jog_velocity = jvel_ff;
	assign zero_offset = zofs_ff;
	assign nv_save_req = nv_save_ff;
	assign cmdbuf_exec = cb_ff;
	assign cmdbuf_high = cbh_ff;
	assign cmdbuf_pair = cbp_ff;
	assign home_ref_sw = href_ff;
	assign ctrl_stop = cstop_ff;
	assign quick_stop = qstop_ff;
	assign gear_activate = gon_ff;
	assign gear_shift = gsh_ff;
	assign gear_shift_dist = gdist_ff;
	assign opmode_out = opmode_ff;

	sequence s_zl_capture;
		zofs_ff == $past(cur_position);
	endsequence
	sequence s_zl_save;
		nv_save_ff;
	endsequence

	AST_OFF_SILENT: assert property (@(posedge hclk) disable iff (!hresetn)
		!any_func |=> !(tstart_ff | hstart_ff | fclr_ff | qstop_ff | gon_ff | cb_ff))
		else $error("Action raised with every input off.");
	AST_FCLR_ONCE: assert property (@(posedge hclk) disable iff (!hresetn)
		fclr_ff |=> !fclr_ff)
		else $error("Fault clear request repeated.");
	AST_FAULT_KEPT: assert property (@(posedge hclk) disable iff (!hresetn)
		fclr_ff |=> ((fault_latch_ff & $past(cond_all)) == $past(cond_all)))
		else $error("Fault cleared while its cause was present.");
	AST_START_GATED: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(tstart_ff) |-> $past(pos_svc))
		else $error("Task start outside position mode with service source.");
	AST_START_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
		locked |=> !(tstart_ff | hstart_ff))
		else $error("Start accepted while a task was active.");
	AST_ZERO_LATCH: assert property (@(posedge hclk) disable iff (!hresetn)
		(zl_trig && zl_state_ff == DIF_ZL_IDLE) |=> s_zl_capture ##1 s_zl_save)
		else $error("Zero latch did not capture and then save.");
	AST_EXT_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
		nxt_ext |=> ext_fault ##1 fault_latch_ff[0])
		else $error("External fault level not raised and latched.");
	AST_QSTOP_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
		qstop_ff |-> $past(qs_ok))
		else $error("Quick stop outside service or gearing source.");
	AST_ENABLE_PATH: assert property (@(posedge hclk) disable iff (!hresetn)
		##2 (drive_enable == $past(enable_in, 2)))
		else $error("Enable output does not follow its input.");
endmodule
`default_nettype wire

// File: verif/dif_switch_model.sv
// Bank of switches on the programmable inputs that can bounce before settling.
`timescale 1ns/1ps
`default_nettype none
module dif_switch_model #(parameter int N_IN = 7) (
	input wire logic hclk,
	input wire logic [N_IN-1:0] target,
	input wire logic bounce,
	output logic [N_IN-1:0] din_raw
);
	logic [N_IN-1:0] stable_ff = '0;
	logic [2:0] n_ff = 3'h0;
	always @(posedge hclk) begin
		if (stable_ff !== target) begin
			if (!bounce || n_ff == 3'h5) begin
				stable_ff <= target;
				n_ff <= 3'h0;
			end else begin
				n_ff <= n_ff + 3'h1;
			end
		end
	end
	// Steps 1 and 3 show the new level for one cycle only, too short to get through the filter.
	assign din_raw = n_ff[0] ? target : stable_ff;
endmodule
`default_nettype wire

// File: verif/tb_digital_input_function_dispatch.sv
// Self-checking bench for the digital input function dispatch.
`timescale 1ns/1ps
`default_nettype none
module tb_digital_input_function_dispatch;
	import dif_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, enable_in, motion_busy, task_done, bounce;
	logic [1:0] htrans, cmdbuf_pair;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, cur_position, jog_velocity, zero_offset, gear_shift_dist, rdv;
	logic [6:0] din_raw, target, task_num;
	logic [15:0] fault_cond, fault_latched;
	logic [7:0] ext_fault_num;
	logic drive_enable, fault_clear_req, ext_fault, task_start, task_cancel, home_start, jog_start;
	logic jog_stop, nv_save_req, cmdbuf_exec, cmdbuf_high, home_ref_sw, ctrl_stop, quick_stop;
	logic gear_activate, gear_shift;
	logic [11:0] pul;
	dif_opmode_t opmode_out;
	int pc[12];
	int rsv[3] = '{7, 12, 14};
	int error_cnt = 0;
	int total_checks = 0;

	dif_top #(.DEB_CYC(2)) dif_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .din_raw, .enable_in,
		.motion_busy, .task_done, .fault_cond, .cur_position, .drive_enable, .fault_clear_req,
		.fault_latched, .ext_fault, .ext_fault_num, .task_start, .task_cancel, .task_num,
		.home_start, .jog_start, .jog_stop, .jog_velocity, .zero_offset, .nv_save_req,
		.cmdbuf_exec, .cmdbuf_high, .cmdbuf_pair, .home_ref_sw, .ctrl_stop, .quick_stop,
		.gear_activate, .gear_shift, .gear_shift_dist, .opmode_out);
	dif_switch_model dif_switch_model_inst (.hclk, .target, .bounce, .din_raw);

	// Pulse counts; index 11 counts high-buffer executions only.
	assign pul = {cmdbuf_exec & cmdbuf_high, gear_shift, gear_activate, quick_stop, cmdbuf_exec,
		nv_save_req, jog_stop, jog_start, home_start, task_cancel, task_start, fault_clear_req};
	always @(posedge hclk) begin
		foreach (pc[i]) begin
			if (pul[i] === 1'b1) begin
				pc[i]++;
			end
		end
	end

	task automatic end_of_test();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, rdv, exp);
	endtask

	task automatic cfg(input logic [2:0] ch, input logic [4:0] f, input logic [31:0] aux);
		bus(1'b1, 8'h10 + {2'h0, ch, 3'h0}, {27'h0, f});
		bus(1'b1, 8'h14 + {2'h0, ch, 3'h0}, aux);
	endtask

	// Long enough for synchroniser, filter, edge stage, output flop and a bounce burst.
	task automatic go(input int ch, input logic v);
		target[ch] <= v;
		repeat (16) @(posedge hclk);
	endtask

	task automatic done_pulse();
		task_done <= 1'b1;
		@(posedge hclk);
		task_done <= 1'b0;
		@(posedge hclk);
	endtask

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	initial begin
		repeat (5000) @(posedge hclk);
		error_cnt++;
		end_of_test();
	end

	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, enable_in, motion_busy, task_done} = '0;
		bounce = 1'b0;
		hsize = 3'h2;
		target = '0;
		fault_cond = '0;
		cur_position = '0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd("fsel", 8'h30, 32'h0);
		chk("hresp", hresp, 0);
		enable_in <= 1'b1;
		fault_cond <= 16'h0018;
		cfg(0, 1, 0);
		fault_cond <= 16'h0008;
		bounce <= 1'b1;
		go(0, 1);
		go(0, 0);
		bounce <= 1'b0;
		chk("clear", pc[0], 1);
		chk("latch", fault_latched, 16'h0008);
		chk("enable", drive_enable, 1);
		cfg(1, 10, 0);
		go(1, 1);
		chk("ext", {ext_fault, ext_fault_num}, 9'h1f5);
		go(1, 0);
		chk("ext0", ext_fault, 0);
		cfg(2, 5, 0);
		go(2, 1);
		go(2, 0);
		chk("gate", pc[3], 0);
		bus(1'b1, 8'h00, 32'h2);
		go(2, 1);
		go(2, 0);
		chk("home", pc[3], 1);
		chk("mode", opmode_out, 2);
		done_pulse();
		cfg(3, 2, 9);
		go(3, 1);
		chk("tnum", task_num, 9);
		go(3, 0);
		go(3, 1);
		chk("lock", pc[1], 1);
		done_pulse();
		motion_busy <= 1'b1;
		go(3, 0);
		go(3, 1);
		chk("busy", pc[1], 1);
		motion_busy <= 1'b0;
		go(3, 0);
		go(3, 1);
		chk("again", pc[1], 2);
		done_pulse();
		go(3, 0);
		cfg(0, 3, 0);
		cfg(1, 3, 0);
		cfg(4, 3, 0);
		cfg(6, 4, 0);
		go(0, 1);
		go(4, 1);
		rd("status", 8'h04, 32'h0009_1105);
		go(6, 1);
		chk("tsel", task_num, 5);
		go(6, 0);
		chk("tstart", pc[1], 3);
		chk("cancel", pc[2], 1);
		done_pulse();
		go(0, 0);
		go(4, 0);
		foreach (rsv[i]) begin
			cfg(5, rsv[i][4:0], 0);
			go(5, 1);
			go(5, 0);
		end
		chk("rsv", pc.sum(), 6);
		cur_position <= 32'h1234abcd;
		cfg(5, 8, 0);
		go(5, 1);
		chk("nvsave", pc[6], 1);
		chk("zoff", zero_offset, 32'h1234abcd);
		rd("zofs", 8'h08, 32'h1234abcd);
		go(5, 0);
		rd("unmap", 8'hf0, 32'h0);
		cfg(5, 6, 32'h64);
		go(5, 1);
		go(5, 0);
		chk("jog", pc[4] + pc[5], 2);
		chk("jogv", jog_velocity, 32'h64);
		cfg(5, 9, 3);
		go(5, 1);
		go(5, 0);
		chk("cbuf", pc[7], 2);
		chk("cbhi", pc[11], 1);
		chk("pair", cmdbuf_pair, 2);
		cfg(5, 11, 0);
		go(5, 1);
		chk("href", home_ref_sw, 1);
		go(5, 0);
		chk("href0", home_ref_sw, 0);
		bus(1'b1, 8'h00, 32'ha);
		cfg(5, 16, 0);
		go(5, 1);
		go(5, 0);
		cfg(5, 17, 32'h5a);
		go(5, 1);
		go(5, 0);
		cfg(5, 15, 0);
		go(5, 1);
		go(5, 0);
		chk("gear", pc[9], 1);
		chk("shift", pc[10], 1);
		chk("dist", gear_shift_dist, 32'h5a);
		chk("qstop", pc[8], 1);
		cfg(5, 13, 0);
		go(5, 1);
		chk("cstop", ctrl_stop, 1);
		go(5, 0);
		end_of_test();
	end
endmodule
`default_nettype wire
